// File: tb_ums_top.sv
// Testbench of the modem status block with modem model and bus master
`default_nettype none
module tb_ums_top;
   timeunit 1ns / 1ns;
   logic i_sys_clk = 0, i_resetn = 0, i_avs_read = 0, i_avs_write = 0;
   logic [3:0] i_avs_address = 4'h0, i_avs_byteenable = 4'h1, want_n = 4'hF;
   logic [31:0] i_avs_writedata = 32'h0, rdat, o_avs_readdata;
   logic [3:0] pins_n;
   logic o_avs_waitrequest, o_irq;
   int err_total = 0, num_checks = 0;
   logic [11:0] rows [7] = '{12'hE11, 12'hC32, 12'h870, 12'h0F8, 12'h4B4,
      12'hF0B, 12'hF00};
   ums_modem modem (.i_clk(i_sys_clk), .i_want_n(want_n), .o_pins_n(pins_n));
   ums_top dut (.i_cts_n(pins_n[0]), .i_dsr_n(pins_n[1]),
      .i_ring_n(pins_n[2]), .i_dcd_n(pins_n[3]), .*);
   initial forever #25 i_sys_clk = ~i_sys_clk;
   task automatic chk(input logic [31:0] got, input logic [31:0] exp);
      num_checks++;
      if (got !== exp)
      begin
         err_total++;
         $display("wrong value at %0t: %h expected %h", $time, got, exp);
      end
   endtask : chk
   task automatic bus(input logic w, input logic [3:0] a, input logic [31:0] d,
      input logic [3:0] be = 4'h1);
      logic wt;
      @(posedge i_sys_clk);
      i_avs_read <= !w;
      i_avs_write <= w;
      i_avs_address <= a;
      i_avs_writedata <= d;
      i_avs_byteenable <= be;
      // Sample where settled; the following rising edge is the acceptance
      do
      begin
         @(negedge i_sys_clk);
         wt = o_avs_waitrequest;
         rdat = o_avs_readdata;
         @(posedge i_sys_clk);
      end
      while (wt !== 1'b0);
      i_avs_read <= 1'b0;
      i_avs_write <= 1'b0;
   endtask : bus
   task automatic final_report;
      if (err_total == 0 && num_checks > 0)
         $display("[ PASS ]");
      else
         $display("[ FAIL ]");
      $finish;
   endtask : final_report
   initial
   begin
      repeat (4) @(posedge i_sys_clk);
      i_resetn <= 1'b1;
      foreach (rows[i])
      begin
         want_n <= rows[i][11:8];
         repeat (8) @(posedge i_sys_clk);
         bus(0, ums_pkg::OFS_STATUS, 32'h0);
         chk({24'h0, rdat[7:0]}, {24'h0, rows[i][7:0]});
      end
      bus(0, ums_pkg::OFS_INT_STAT, 32'h0);
      chk(rdat & 32'hF, 32'hF);
      bus(1, ums_pkg::OFS_INT_MASK, 32'hF);
      @(posedge i_sys_clk);
      chk(32'(o_irq), 32'h1);
      bus(1, ums_pkg::OFS_INT_STAT, 32'hF);
      @(posedge i_sys_clk);
      chk(32'(o_irq), 32'h0);
      // A ring falling edge must stay silent; only its release counts
      want_n <= 4'hB;
      repeat (8) @(posedge i_sys_clk);
      chk(32'(o_irq), 32'h0);
      want_n <= 4'hF;
      repeat (8) @(posedge i_sys_clk);
      chk(32'(o_irq), 32'h1);
      bus(1, ums_pkg::OFS_INT_MASK, 32'h0, 4'h0);
      @(posedge i_sys_clk);
      chk(32'(o_irq), 32'h1);
      bus(1, ums_pkg::OFS_STATUS, 32'hFF);
      bus(0, ums_pkg::OFS_STATUS, 32'h0);
      chk({24'h0, rdat[7:0]}, 32'h4);
      bus(0, 4'hC, 32'h0);
      chk(rdat, ums_pkg::UNMAPPED_DATA);
      i_resetn <= 1'b0;
      repeat (4) @(posedge i_sys_clk);
      i_resetn <= 1'b1;
      bus(0, ums_pkg::OFS_INT_MASK, 32'h0);
      chk(rdat & 32'hF, {28'h0, ums_pkg::RST_MASK});
      final_report;
   end
   initial
   begin
      #100000;
      err_total++;
      final_report;
   end
endmodule : tb_ums_top
`default_nettype wire

// File: ums_assertions.sv
// Checker of bus timing and status bits of the modem status block
`default_nettype none
module ums_assertions (
   input wire logic i_sys_clk, i_resetn, i_cts_n, i_dsr_n, i_ring_n,
   input wire logic i_dcd_n, i_avs_read, i_avs_write, o_avs_waitrequest,
   input wire logic o_irq,
   input wire logic [ums_pkg::ADDR_W-1:0] i_avs_address,
   input wire logic [31:0] o_avs_readdata
);
   timeunit 1ns / 1ns;
   default clocking @(posedge i_sys_clk); endclocking
   default disable iff (!i_resetn);
   logic [2:0] c_q;
   logic cl_q;
   // Levels are trusted only after the lines sat still past the sync lag
   wire q = &c_q;
   wire rd0 = i_avs_read & ~o_avs_waitrequest & (i_avs_address == 4'h0);
   always_ff @(posedge i_sys_clk)
   begin
      if (!i_resetn || !$stable({i_dcd_n, i_ring_n, i_dsr_n, i_cts_n}))
      begin
         c_q <= 3'h0;
         cl_q <= 1'b0;
      end
      else
      begin
         c_q <= c_q + {2'h0, !q};
         cl_q <= cl_q | (rd0 & q);
      end
   end
   chk_ring_level: assert property (
      rd0 && q |-> o_avs_readdata[6] == !i_ring_n)
      else $error("ring level bit");
   chk_ready_level: assert property (
      rd0 && q |-> o_avs_readdata[5] != i_dsr_n)
      else $error("ready level bit");
   chk_cts_level: assert property (
      rd0 && q |-> o_avs_readdata[4] ^ i_cts_n)
      else $error("clear level bit");
   chk_carrier_level: assert property (
      rd0 && q |-> !o_avs_readdata[7] == i_dcd_n)
      else $error("carrier level bit");
   chk_read_clears: assert property (
      rd0 && cl_q |-> o_avs_readdata[3:0] == 4'h0)
      else $error("flags survived read");
   chk_wait_one: assert property ((i_avs_read || i_avs_write) &&
      o_avs_waitrequest |=> !o_avs_waitrequest) else $error("late answer");
   chk_idle_nowait: assert property (!(i_avs_read || i_avs_write) |->
      !o_avs_waitrequest) else $error("wait while idle");
   chk_unmapped_zero: assert property (i_avs_read && !o_avs_waitrequest &&
      i_avs_address == 4'hC |-> o_avs_readdata == 32'h0) else $error("unmapped");
   cover property (rd0 && o_avs_readdata[2]);
   cover property ($rose(o_irq));
   cover property (rd0 && cl_q);
endmodule : ums_assertions
bind ums_top ums_assertions chk (.*);
`default_nettype wire

// File: ums_modem.sv
// Modem model that drives the four active-low status lines
`default_nettype none
module ums_modem (
   input wire logic i_clk,
   input wire logic [3:0] i_want_n,
   output logic [3:0] o_pins_n
);
   timeunit 1ns / 1ns;
   always_ff @(posedge i_clk) o_pins_n <= i_want_n;
endmodule : ums_modem
`default_nettype wire

// File: ums_pin_if.sv
// Interface carrying synchronised modem levels and edge pulses
`default_nettype none
interface ums_pin_if;
   logic [3:0] level_n;
   logic [3:0] rise;
   logic [3:0] change;
   modport src (output level_n, output rise, output change);
   modport dst (input level_n, input rise, input change);
endinterface : ums_pin_if
`default_nettype wire

// File: ums_pkg.sv
// Package of register map, field positions and reset values for modem status
`default_nettype none
package ums_pkg;
   localparam int ADDR_W = 4;
   localparam logic [ADDR_W-1:0] OFS_STATUS = 4'h0;
   localparam logic [ADDR_W-1:0] OFS_INT_STAT = 4'h4;
   localparam logic [ADDR_W-1:0] OFS_INT_MASK = 4'h8;
   localparam int BIT_DCTS = 0;
   localparam int BIT_DDSR = 1;
   localparam int BIT_TERI = 2;
   localparam int BIT_DDCD = 3;
   localparam int BIT_CTS = 4;
   localparam int BIT_DSR = 5;
   localparam int BIT_RI = 6;
   localparam int BIT_DCD = 7;
   localparam logic [3:0] RST_DELTA = 4'h0;
   localparam logic [3:0] RST_MASK = 4'h0;
   localparam logic [3:0] RST_PINS_N = 4'hF;
   localparam logic [31:0] UNMAPPED_DATA = 32'h0000_0000;
   typedef enum logic [1:0] {
      UMS_IDLE = 2'b00,
      UMS_ANSWER = 2'b01
   } ums_bus_e;
endpackage : ums_pkg
`default_nettype wire

// File: ums_sync.sv
// Two-stage synchroniser and edge detector for the four modem inputs
`default_nettype none
module ums_sync #(
   parameter int N = 4
) (
   input wire logic i_sys_clk,
   input wire logic i_resetn,
   input wire logic [N-1:0] i_pins_n,
   ums_pin_if.src o_pin
);
   typedef struct packed {
      logic [N-1:0] meta;
      logic [N-1:0] sync;
      logic [N-1:0] last;
   } ums_sync_s;
   ums_sync_s st_q, st_d;

   always_comb
   begin
      st_d = st_q;
      st_d.meta = i_pins_n;
      st_d.sync = st_q.meta;
      st_d.last = st_q.sync;
   end

   always_ff @(posedge i_sys_clk)
   begin
      if (!i_resetn)
      begin
         st_q.meta <= ums_pkg::RST_PINS_N;
         st_q.sync <= ums_pkg::RST_PINS_N;
         st_q.last <= ums_pkg::RST_PINS_N;
      end
      else
      begin
         st_q <= st_d;
      end
   end

   // Edges taken only from the second stage
   assign o_pin.level_n = st_q.sync;
   assign o_pin.rise = st_q.sync & ~st_q.last;
   assign o_pin.change = st_q.sync ^ st_q.last;
endmodule : ums_sync
`default_nettype wire

// File: ums_top.sv
// Modem status inputs with Avalon-MM register slave and interrupt
// Operation
// R1: Bit 6 reads inverse of ring input
// R2: Bit 2 sets on ring low-to-high only
// R3: Bit 5 reads inverse of data-set-ready
// R4: Bit 1 sets on any data-set-ready change
// R5: Bit 4 reads inverse of clear-to-send
// R6: Four inputs drive flags and interrupt
// R7: Reading status clears change flags
// R8: Modem drives ring and ready low
// R9: Bit 0 sets on clear-to-send change
// R10: Bit 7 carrier inverse, bit 3 change
// R11: Synchronise inputs, interrupt while flag enabled
`default_nettype none
module ums_top (
   input wire logic i_sys_clk,
   input wire logic i_resetn,
   input wire logic i_cts_n,
   input wire logic i_dsr_n,
   input wire logic i_ring_n,
   input wire logic i_dcd_n,
   input wire logic [ums_pkg::ADDR_W-1:0] i_avs_address,
   input wire logic i_avs_read,
   input wire logic i_avs_write,
   input wire logic [31:0] i_avs_writedata,
   input wire logic [3:0] i_avs_byteenable,
   output logic [31:0] o_avs_readdata,
   output logic o_avs_waitrequest,
   output logic o_irq
);
   typedef struct packed {
      ums_pkg::ums_bus_e bus;
      logic [3:0] delta;
      logic [3:0] int_stat;
      logic [3:0] int_mask;
      logic [31:0] rdata;
   } ums_top_s;
   ums_top_s st_q, st_d;

   ums_pin_if pin ();
   logic [3:0] ev;
   logic [7:0] status;
   logic req;
   logic take;
   logic rd_status;
   logic [3:0] w1c;

   // Input order: cts, dsr, ring, dcd matches flag bits 0..3
   ums_sync #(.N(4)) u_sync (
      .i_sys_clk(i_sys_clk),
      .i_resetn(i_resetn),
      .i_pins_n({i_dcd_n, i_ring_n, i_dsr_n, i_cts_n}), // R11
      .o_pin(pin)
   );

   always_comb
   begin
      ev = '0;
      ev[ums_pkg::BIT_DCTS] = pin.change[0]; // R9
      ev[ums_pkg::BIT_DDSR] = pin.change[1]; // R4
      ev[ums_pkg::BIT_TERI] = pin.rise[2]; // R2
      ev[ums_pkg::BIT_DDCD] = pin.change[3]; // R10
   end

   always_comb
   begin
      status = '0;
      status[3:0] = st_q.delta;
      status[ums_pkg::BIT_CTS] = ~pin.level_n[0]; // R5
      status[ums_pkg::BIT_DSR] = ~pin.level_n[1]; // R3
      status[ums_pkg::BIT_RI] = ~pin.level_n[2]; // R1
      status[ums_pkg::BIT_DCD] = ~pin.level_n[3]; // R10
   end

   // One wait cycle lets the read data come from a register
   assign req = i_avs_read | i_avs_write;
   assign take = req & (st_q.bus == ums_pkg::UMS_ANSWER);
   assign rd_status = take & i_avs_read
                      & (i_avs_address == ums_pkg::OFS_STATUS);
   assign w1c = (take && i_avs_write && i_avs_byteenable[0]
                 && i_avs_address == ums_pkg::OFS_INT_STAT)
                ? i_avs_writedata[3:0] : 4'h0;

   always_comb
   begin
      st_d = st_q;
      unique case (st_q.bus)
         ums_pkg::UMS_IDLE:
         begin
            if (req)
            begin
               st_d.bus = ums_pkg::UMS_ANSWER;
               st_d.rdata = ums_pkg::UNMAPPED_DATA;
               if (i_avs_read)
               begin
                  unique case (i_avs_address)
                     ums_pkg::OFS_STATUS: st_d.rdata[7:0] = status;
                     ums_pkg::OFS_INT_STAT: st_d.rdata[3:0] = st_q.int_stat;
                     ums_pkg::OFS_INT_MASK: st_d.rdata[3:0] = st_q.int_mask;
                     default: st_d.rdata = ums_pkg::UNMAPPED_DATA;
                  endcase
               end
            end
         end
         ums_pkg::UMS_ANSWER:
         begin
            st_d.bus = ums_pkg::UMS_IDLE;
         end
      endcase
      // Clear on read, but an edge in the same cycle survives
      st_d.delta = (st_q.delta & ~(rd_status ? 4'hF : 4'h0)) | ev; // R7
      st_d.int_stat = (st_q.int_stat & ~w1c) | ev; // R6
      if (take && i_avs_write && i_avs_byteenable[0]
          && i_avs_address == ums_pkg::OFS_INT_MASK)
      begin
         st_d.int_mask = i_avs_writedata[3:0];
      end
   end

   always_ff @(posedge i_sys_clk)
   begin
      if (!i_resetn)
      begin
         st_q.bus <= ums_pkg::UMS_IDLE;
         st_q.delta <= ums_pkg::RST_DELTA;
         st_q.int_stat <= ums_pkg::RST_DELTA;
         st_q.int_mask <= ums_pkg::RST_MASK;
         st_q.rdata <= ums_pkg::UNMAPPED_DATA;
      end
      else
      begin
         st_q <= st_d;
      end
   end

   assign o_avs_waitrequest = req & (st_q.bus == ums_pkg::UMS_IDLE);
   assign o_avs_readdata = st_q.rdata;
   assign o_irq = |(st_q.int_stat & st_q.int_mask); // R11
endmodule : ums_top
`default_nettype wire
